// >>> include/cpcu_pkg.sv
// Contract
// R1: Four capture prescaler settings are selected by the unit's mode bits.
// R2: Prescaler counter stays zero while the unit is off or not capturing.
// R3: Any reset clears the capture prescaler counter.
// R4: Switching directly between prescaler settings does not clear the counter.
// R5: Software should write zero, then the new mode, to switch prescalers.
// R6: Compare mode continuously compares the 16-bit value with the timer count.
// R7: On match the pin goes high, goes low or stays, per mode bits.
// R8: Every compare match sets the unit flag together with the pin action.
// R9: Writing zero to the control register forces the output latch low.
// R10: Software must make the compare pin an output before relying on it.
// R11: The timer must run synchronously while compare is in use.
// R12: Software interrupt mode leaves the pin alone and only flags.
// R13: Special event trigger mode resets the timer count on match.
// R14: The special event trigger also starts an analog conversion.
// R15: A trigger-caused timer reset never sets the timer overflow flag.
// R16: The trigger is one clock pulse per first detected equality.
package cpcu_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [2:0] OFF_CTRL = 3'h0;
  localparam logic [2:0] OFF_VAL_LO = 3'h1;
  localparam logic [2:0] OFF_VAL_HI = 3'h2;
  localparam logic [2:0] OFF_STATUS = 3'h3;
  localparam logic [2:0] OFF_MASK = 3'h4;
  localparam logic [2:0] OFF_PSC = 3'h5;
  localparam int CTRL_W = 6;
  localparam int MODE_LSB = 0;
  localparam int STAT_W = 2;
  localparam int STAT_UNIT_BIT = 0;
  localparam int STAT_EVENT_BIT = 1;
  localparam logic [5:0] RST_CTRL = 6'h00;
  localparam logic [7:0] RST_VAL = 8'h00;
  localparam logic [1:0] RST_STAT = 2'h0;
  localparam logic [1:0] RST_MASK = 2'h0;
  localparam logic [3:0] RST_PSC = 4'h0;
  localparam logic [3:0] PSC_LIM_1 = 4'h0;
  localparam logic [3:0] PSC_LIM_4 = 4'h3;
  localparam logic [3:0] PSC_LIM_16 = 4'hF;
  localparam logic ADC_TRIGGER_EN = 1'b1;
  typedef enum logic [3:0] {
    MODE_OFF = 4'h0,
    MODE_CAP_FALL = 4'h4,
    MODE_CAP_RISE = 4'h5,
    MODE_CAP_RISE4 = 4'h6,
    MODE_CAP_RISE16 = 4'h7,
    MODE_CMP_HIGH = 4'h8,
    MODE_CMP_LOW = 4'h9,
    MODE_CMP_SWI = 4'hA,
    MODE_CMP_SPECIAL = 4'hB
  } cpcu_mode_type;
  typedef enum logic [1:0] {
    PS_FALL1 = 2'h0,
    PS_RISE1 = 2'h1,
    PS_RISE4 = 2'h2,
    PS_RISE16 = 2'h3
  } cpcu_psc_type;
endpackage

// >>> include/cpcu_psc_if.sv
`timescale 1ns/10ps
interface cpcu_psc_if;
  logic captureMode;
  logic [1:0] psSel;
  logic edgeSeen;
  logic captureFire;
  logic [3:0] psCount;
  modport ctl (output captureMode, output psSel, output edgeSeen,
               input captureFire, input psCount);
  modport psc (input captureMode, input psSel, input edgeSeen,
               output captureFire, output psCount);
endinterface

// >>> logic/cpcu_prescaler.sv
`timescale 1ns/10ps
module cpcu_prescaler (
  input wire logic clk,
  input wire logic reset_n,
  cpcu_psc_if.psc psc
);
  logic [3:0] count_r;
  logic fire_r;
  logic [3:0] limit;

  function automatic logic [3:0] psLimit(input logic [1:0] sel);
    unique case (cpcu_pkg::cpcu_psc_type'(sel))
      cpcu_pkg::PS_RISE4: psLimit = cpcu_pkg::PSC_LIM_4;
      cpcu_pkg::PS_RISE16: psLimit = cpcu_pkg::PSC_LIM_16;
      default: psLimit = cpcu_pkg::PSC_LIM_1;
    endcase
  endfunction

  assign limit = psLimit(psc.psSel); // see R1

  // A count above a newly chosen smaller limit wraps on the next edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= cpcu_pkg::RST_PSC; // see R3
    end else if (!psc.captureMode) begin
      count_r <= cpcu_pkg::RST_PSC; // see R2
    end else if (psc.edgeSeen) begin
      if (count_r >= limit) begin
        count_r <= cpcu_pkg::RST_PSC;
      end else begin
        count_r <= count_r + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fire_r <= 1'b0;
    end else begin
      fire_r <= psc.captureMode && psc.edgeSeen && (count_r >= limit);
    end
  end

  assign psc.captureFire = fire_r;
  assign psc.psCount = count_r;

  property p_psc_idle_zero;
    @(posedge clk) disable iff (!reset_n)
    !psc.captureMode |=> (count_r == 4'h0);
  endproperty
  a_psc_idle_zero: assert property (p_psc_idle_zero) // see R2
    else $error("prescaler count not zero while not capturing");

  property p_psc_no_clear;
    @(posedge clk) disable iff (!reset_n)
    (psc.captureMode && !psc.edgeSeen) |=> (count_r == $past(count_r));
  endproperty
  a_psc_no_clear: assert property (p_psc_no_clear) // see R4
    else $error("prescaler count changed without an edge");

  property p_psc_div16;
    @(posedge clk) disable iff (!reset_n)
    (psc.captureMode && psc.edgeSeen && psc.psSel == 2'h3 && count_r == 4'hE)
      |=> !fire_r ##0 (count_r == 4'hF);
  endproperty
  a_psc_div16: assert property (p_psc_div16) // see R1
    else $error("divide by sixteen fired early");
endmodule

// >>> logic/cpcu_top.sv
`timescale 1ns/10ps
module cpcu_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic [15:0] timerCount,
  input wire logic captureIn,
  output logic comparePinOut,
  output logic comparePinOe,
  output logic timerOneClear,
  output logic adcStart,
  output logic irq
);
  cpcu_psc_if pscBus ();

  logic [5:0] ctrl_r;
  logic [7:0] valueLo_r;
  logic [7:0] valueHi_r;
  logic [1:0] status_r;
  logic [1:0] mask_r;
  logic [7:0] rdata_r;
  logic pinLatch_r;
  logic pinOe_r;
  logic trig_r;
  logic adc_r;
  logic irq_r;
  logic matchPrev_r;
  logic capSync1_r;
  logic capSync2_r;
  logic capSync3_r;
  logic capLevel_r;

  cpcu_pkg::cpcu_mode_type mode;
  logic [15:0] compareValue;
  logic capStable;
  logic capRise;
  logic capFall;
  logic matchNow;
  logic matchPulse;
  logic ctrlWrite;
  logic ctrlZero;
  logic statusWrite;
  logic [1:0] statusSet;
  logic [1:0] statusClr;

  function automatic logic isCompare(input cpcu_pkg::cpcu_mode_type m);
    isCompare = (m == cpcu_pkg::MODE_CMP_HIGH) || (m == cpcu_pkg::MODE_CMP_LOW) ||
                (m == cpcu_pkg::MODE_CMP_SWI) || (m == cpcu_pkg::MODE_CMP_SPECIAL);
  endfunction

  function automatic logic isCapture(input cpcu_pkg::cpcu_mode_type m);
    isCapture = (m == cpcu_pkg::MODE_CAP_FALL) || (m == cpcu_pkg::MODE_CAP_RISE) ||
                (m == cpcu_pkg::MODE_CAP_RISE4) || (m == cpcu_pkg::MODE_CAP_RISE16);
  endfunction

  function automatic logic isRegWrite(input logic wr, input logic [2:0] a,
                                      input logic [2:0] off);
    isRegWrite = wr && (a == off);
  endfunction

  assign mode = cpcu_pkg::cpcu_mode_type'(ctrl_r[cpcu_pkg::MODE_LSB +: 4]);
  assign compareValue = {valueHi_r, valueLo_r};
  assign ctrlWrite = isRegWrite(regWr, regAddr, cpcu_pkg::OFF_CTRL);
  assign ctrlZero = ctrlWrite && (regWdata == 8'h00);
  assign statusWrite = isRegWrite(regWr, regAddr, cpcu_pkg::OFF_STATUS);

  // Capture input synchroniser; only stages two and three are examined
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      capSync1_r <= 1'b0;
      capSync2_r <= 1'b0;
      capSync3_r <= 1'b0;
    end else begin
      capSync1_r <= captureIn;
      capSync2_r <= capSync1_r;
      capSync3_r <= capSync2_r;
    end
  end

  assign capStable = (capSync2_r == capSync3_r);
  assign capRise = capStable && capSync3_r && !capLevel_r;
  assign capFall = capStable && !capSync3_r && capLevel_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      capLevel_r <= 1'b0;
    end else if (capStable) begin
      capLevel_r <= capSync3_r;
    end
  end

  // Prescaler sees only the edge polarity of the active capture mode
  assign pscBus.captureMode = isCapture(mode); // see R2
  assign pscBus.psSel = ctrl_r[1:0]; // see R1
  assign pscBus.edgeSeen = (mode == cpcu_pkg::MODE_CAP_FALL) ? capFall : capRise;

  cpcu_prescaler u_prescaler (
    .clk(clk),
    .reset_n(reset_n),
    .psc(pscBus.psc)
  );

  // Control register; a direct change between capture modes keeps the prescaler count
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= cpcu_pkg::RST_CTRL;
    end else if (ctrlWrite) begin
      ctrl_r <= regWdata[5:0]; // see R4
    end
  end

  // Value word: capture wins over a software write in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      valueLo_r <= cpcu_pkg::RST_VAL;
      valueHi_r <= cpcu_pkg::RST_VAL;
    end else if (pscBus.captureFire) begin
      valueLo_r <= timerCount[7:0];
      valueHi_r <= timerCount[15:8];
    end else if (regWr && regAddr == cpcu_pkg::OFF_VAL_LO) begin
      valueLo_r <= regWdata;
    end else if (regWr && regAddr == cpcu_pkg::OFF_VAL_HI) begin
      valueHi_r <= regWdata;
    end
  end

  // Equality is level; only its first cycle counts as a match
  assign matchNow = isCompare(mode) && (compareValue == timerCount); // see R6
  assign matchPulse = matchNow && !matchPrev_r; // see R16

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      matchPrev_r <= 1'b0;
    end else begin
      matchPrev_r <= matchNow;
    end
  end

  // Compare output latch; clearing control wins over a same-cycle match
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pinLatch_r <= 1'b0;
    end else if (ctrlZero) begin
      pinLatch_r <= 1'b0; // see R9
    end else if (matchPulse) begin
      unique case (mode)
        cpcu_pkg::MODE_CMP_HIGH: pinLatch_r <= 1'b1; // see R7
        cpcu_pkg::MODE_CMP_LOW: pinLatch_r <= 1'b0; // see R7
        cpcu_pkg::MODE_CMP_SWI: pinLatch_r <= pinLatch_r; // see R12
        cpcu_pkg::MODE_CMP_SPECIAL: pinLatch_r <= pinLatch_r;
        default: pinLatch_r <= pinLatch_r;
      endcase
    end
  end

  // Pin driven only in the pin-action compare modes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pinOe_r <= 1'b0;
    end else begin
      pinOe_r <= (mode == cpcu_pkg::MODE_CMP_HIGH) || (mode == cpcu_pkg::MODE_CMP_LOW);
    end
  end

  // Trigger is its own clear strobe, never an overflow, so the timer
  // has no reason to raise its overflow flag
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      trig_r <= 1'b0;
      adc_r <= 1'b0;
    end else begin
      trig_r <= matchPulse && (mode == cpcu_pkg::MODE_CMP_SPECIAL); // see R13 see R15
      adc_r <= matchPulse && (mode == cpcu_pkg::MODE_CMP_SPECIAL) &&
               cpcu_pkg::ADC_TRIGGER_EN; // see R14
    end
  end

  // Sticky status; a new event beats a write-one-to-clear
  assign statusSet[cpcu_pkg::STAT_UNIT_BIT] = matchPulse || pscBus.captureFire; // see R8
  assign statusSet[cpcu_pkg::STAT_EVENT_BIT] = matchPulse &&
                                               (mode == cpcu_pkg::MODE_CMP_SPECIAL);
  assign statusClr = statusWrite ? regWdata[1:0] : 2'h0;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_r <= cpcu_pkg::RST_STAT;
    end else begin
      status_r <= (status_r & ~statusClr) | statusSet; // see R8 see R12
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_r <= cpcu_pkg::RST_MASK;
    end else if (isRegWrite(regWr, regAddr, cpcu_pkg::OFF_MASK)) begin
      mask_r <= regWdata[1:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_r & mask_r);
    end
  end

  // Read data stand one cycle only; unmapped offsets read zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= 8'h00;
    end else if (regRd) begin
      unique case (regAddr)
        cpcu_pkg::OFF_CTRL: rdata_r <= {2'h0, ctrl_r};
        cpcu_pkg::OFF_VAL_LO: rdata_r <= valueLo_r;
        cpcu_pkg::OFF_VAL_HI: rdata_r <= valueHi_r;
        cpcu_pkg::OFF_STATUS: rdata_r <= {6'h00, status_r};
        cpcu_pkg::OFF_MASK: rdata_r <= {6'h00, mask_r};
        cpcu_pkg::OFF_PSC: rdata_r <= {4'h0, pscBus.psCount};
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign regRdata = rdata_r;
  assign comparePinOut = pinLatch_r;
  assign comparePinOe = pinOe_r;
  assign timerOneClear = trig_r;
  assign adcStart = adc_r;
  assign irq = irq_r;

  property p_match_flag;
    @(posedge clk) disable iff (!reset_n)
    matchPulse |=> status_r[0];
  endproperty
  a_match_flag: assert property (p_match_flag) // see R8
    else $error("match did not set the unit flag");

  property p_pin_high;
    @(posedge clk) disable iff (!reset_n)
    (matchPulse && mode == cpcu_pkg::MODE_CMP_HIGH && !ctrlZero)
      |=> comparePinOut && status_r[0];
  endproperty
  a_pin_high: assert property (p_pin_high) // see R7
    else $error("pin not driven high on match");

  property p_pin_low;
    @(posedge clk) disable iff (!reset_n)
    (matchPulse && mode == cpcu_pkg::MODE_CMP_LOW) |=> !comparePinOut;
  endproperty
  a_pin_low: assert property (p_pin_low) // see R7
    else $error("pin not driven low on match");

  property p_zero_ctrl;
    @(posedge clk) disable iff (!reset_n)
    ctrlZero |=> !comparePinOut && (ctrl_r == 6'h00);
  endproperty
  a_zero_ctrl: assert property (p_zero_ctrl) // see R9
    else $error("clearing control left the latch high");

  property p_swi_pin;
    @(posedge clk) disable iff (!reset_n)
    (mode == cpcu_pkg::MODE_CMP_SWI && !ctrlZero) |=> $stable(comparePinOut);
  endproperty
  a_swi_pin: assert property (p_swi_pin) // see R12
    else $error("software interrupt mode moved the pin");

  property p_trig_cause;
    @(posedge clk) disable iff (!reset_n)
    (matchPulse && mode == cpcu_pkg::MODE_CMP_SPECIAL)
      |=> timerOneClear && adcStart && status_r[1];
  endproperty
  a_trig_cause: assert property (p_trig_cause) // see R13
    else $error("special event match gave no trigger");

  property p_trig_single;
    @(posedge clk) disable iff (!reset_n)
    timerOneClear |=> !timerOneClear;
  endproperty
  a_trig_single: assert property (p_trig_single) // see R16
    else $error("trigger wider than one cycle");

  property p_trig_equal;
    @(posedge clk) disable iff (!reset_n)
    timerOneClear |-> ($past(compareValue) == $past(timerCount)) && !$past(matchPrev_r);
  endproperty
  a_trig_equal: assert property (p_trig_equal) // see R6
    else $error("trigger without first equality");

  // No disable here: the clear must hold while the clock keeps running in reset
  property p_psc_reset;
    @(posedge clk)
    (!reset_n ##1 !reset_n) |-> (pscBus.psCount == 4'h0);
  endproperty
  a_psc_reset: assert property (p_psc_reset) // see R3
    else $error("prescaler count survived a reset");

  property p_trig_adc;
    @(posedge clk) disable iff (!reset_n)
    timerOneClear |-> adcStart;
  endproperty
  a_trig_adc: assert property (p_trig_adc) // see R14
    else $error("trigger without conversion start");

  property p_trig_only_special;
    @(posedge clk) disable iff (!reset_n)
    !(matchPulse && mode == cpcu_pkg::MODE_CMP_SPECIAL) |=> !timerOneClear && !adcStart;
  endproperty
  a_trig_only_special: assert property (p_trig_only_special) // see R13
    else $error("trigger outside a special event match");

  property p_irq_set;
    @(posedge clk) disable iff (!reset_n)
    (|(status_r & mask_r)) |=> irq;
  endproperty
  a_irq_set: assert property (p_irq_set) // see R12
    else $error("unmasked flag raised no interrupt");

  property p_irq_clear;
    @(posedge clk) disable iff (!reset_n)
    (~|(status_r & mask_r)) |=> !irq;
  endproperty
  a_irq_clear: assert property (p_irq_clear) // see R12
    else $error("interrupt without an unmasked flag");

  property p_match_once;
    @(posedge clk) disable iff (!reset_n)
    (matchNow && matchPrev_r && !ctrlZero) |=> $stable(comparePinOut) && !timerOneClear;
  endproperty
  a_match_once: assert property (p_match_once) // see R16
    else $error("lasting equality acted twice");

  property p_capture_load;
    @(posedge clk) disable iff (!reset_n)
    pscBus.captureFire |=> status_r[0] && (compareValue == $past(timerCount));
  endproperty
  a_capture_load: assert property (p_capture_load) // see R1
    else $error("capture did not load the count and flag");
endmodule

// >>> tb/capture_prescaler_compare_unit_test.sv
`timescale 1ns/10ps
module capture_prescaler_compare_unit_test;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic captureIn = 1'b0;
  logic run = 1'b0;
  logic restart = 1'b0;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] rd;
  logic [7:0] regRdata;
  logic comparePinOut;
  logic comparePinOe;
  logic timerOneClear;
  logic adcStart;
  logic irq;
  logic ovf;
  logic [15:0] tmrCnt;
  logic [7:0] convCnt;
  // Rows: mode, pin after match, output enable, trigger
  logic [6:0] rows [4] = '{7'h46, 7'h54, 7'h4A, 7'h59};
  logic [4:0] need [4] = '{5'h01, 5'h01, 5'h04, 5'h10};
  int err_total = 0;
  int n_tests = 0;
  always #10 clk = ~clk;
  cpcu_top dut (.clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .timerCount(tmrCnt),
    .captureIn(captureIn), .comparePinOut(comparePinOut), .comparePinOe(comparePinOe),
    .timerOneClear(timerOneClear), .adcStart(adcStart), .irq(irq));
  cpcu_timer_model tmr (.clk(clk), .reset_n(reset_n), .run(run), .restart(restart),
    .timerClear(timerOneClear), .convStart(adcStart), .count(tmrCnt), .ovfFlag(ovf),
    .convCount(convCnt));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task rdr(input logic [2:0] a);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 rd = regRdata;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task waitCnt(input logic [15:0] v);
    for (int k = 0; k < 400 && tmrCnt !== v; k++) cyc(1);
  endtask
  task pulse;
    @(posedge clk);
    captureIn <= 1'b1;
    cyc(4);
    @(posedge clk);
    captureIn <= 1'b0;
    cyc(4);
  endtask
  task restartTimer(input logic [3:0] mode);
    @(posedge clk);
    run <= 1'b0;
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
    wr(cpcu_pkg::OFF_STATUS, 8'h03);
    wr(cpcu_pkg::OFF_CTRL, {4'h0, mode});
    @(posedge clk);
    run <= 1'b1;
  endtask
  task results;
    $display("mismatches %0d of %0d comparisons", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    // Whole run is under two thousand cycles
    #400000;
    err_total++;
    results();
  end
  // Shared by the start-up and the mid-run reset
  task afterReset;
    reset_n <= 1'b1;
    cyc(1);
    chk({3'h0, comparePinOut, comparePinOe, timerOneClear, adcStart, irq}, 8'h00);
    for (int a = 0; a < 8; a++) begin
      rdr(3'(a));
      chk(rd, 8'h00);
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    afterReset();
    wr(cpcu_pkg::OFF_VAL_LO, 8'h03);
    wr(cpcu_pkg::OFF_VAL_HI, 8'h01);
    wr(cpcu_pkg::OFF_MASK, 8'h01);
    for (int i = 0; i < 4; i++) begin
      restartTimer(rows[i][6:3]);
      waitCnt(16'h0103);
      cyc(1);
      chk(8'(comparePinOut), 8'(rows[i][2]));
      chk(8'(comparePinOe), 8'(rows[i][1]));
      chk(8'(timerOneClear), 8'(rows[i][0]));
      chk(8'(adcStart), 8'(rows[i][0]));
      cyc(1);
      chk(8'(timerOneClear), 8'h00);
      chk(8'(irq), 8'h01);
      rdr(cpcu_pkg::OFF_STATUS);
      chk(rd, {6'h00, rows[i][0], 1'b1});
      rdr(cpcu_pkg::OFF_PSC);
      chk(rd, 8'h00);
    end
    chk(8'(ovf), 8'h00);
    chk(convCnt, 8'h01);
    // Stop the timer right on the compare value
    wr(cpcu_pkg::OFF_CTRL, 8'h00);
    restartTimer(4'h8);
    waitCnt(16'h0102);
    @(posedge clk);
    run <= 1'b0;
    cyc(3);
    chk(8'(comparePinOut), 8'h01);
    chk(8'(irq), 8'h01);
    wr(cpcu_pkg::OFF_MASK, 8'h00);
    cyc(2);
    chk(8'(irq), 8'h00);
    wr(cpcu_pkg::OFF_STATUS, 8'h01);
    wr(cpcu_pkg::OFF_MASK, 8'h01);
    cyc(6);
    rdr(cpcu_pkg::OFF_STATUS);
    chk(rd, 8'h00);
    chk(8'(irq), 8'h00);
    wr(cpcu_pkg::OFF_CTRL, 8'h00);
    cyc(1);
    chk(8'(comparePinOut), 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(cpcu_pkg::OFF_CTRL, 8'h00);
      wr(cpcu_pkg::OFF_STATUS, 8'h03);
      wr(cpcu_pkg::OFF_CTRL, 8'h04 + 8'(m));
      repeat (need[m] - 5'h01) pulse();
      rdr(cpcu_pkg::OFF_STATUS);
      chk(rd, 8'h00);
      pulse();
      rdr(cpcu_pkg::OFF_STATUS);
      chk(rd, 8'h01);
    end
    wr(cpcu_pkg::OFF_CTRL, 8'h00);
    wr(cpcu_pkg::OFF_CTRL, 8'h06);
    pulse();
    pulse();
    rdr(cpcu_pkg::OFF_PSC);
    chk(rd, 8'h02);
    wr(cpcu_pkg::OFF_CTRL, 8'h07);
    rdr(cpcu_pkg::OFF_PSC);
    chk(rd, 8'h02);
    wr(cpcu_pkg::OFF_CTRL, 8'h00);
    rdr(cpcu_pkg::OFF_PSC);
    chk(rd, 8'h00);
    wr(cpcu_pkg::OFF_CTRL, 8'h07);
    pulse();
    wr(cpcu_pkg::OFF_CTRL, 8'h08);
    rdr(cpcu_pkg::OFF_PSC);
    chk(rd, 8'h00);
    chk(8'(comparePinOut), 8'h01);
    // Leave every register non-zero, then reset in mid-run
    wr(cpcu_pkg::OFF_CTRL, 8'h07);
    pulse();
    rdr(cpcu_pkg::OFF_PSC);
    chk(rd, 8'h01);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    afterReset();
    results();
  end
endmodule

// >>> tb/cpcu_timer_model.sv
`timescale 1ns/10ps
module cpcu_timer_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic restart,
  input wire logic timerClear,
  input wire logic convStart,
  output logic [15:0] count,
  output logic ovfFlag,
  output logic [7:0] convCount
);
  // Counts on the system clock only, never asynchronously
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= 16'h0000;
      ovfFlag <= 1'b0;
    end else if (restart || timerClear) begin
      // A trigger clear is not a wrap, so no flag
      count <= 16'h0000;
    end else if (run) begin
      count <= count + 16'h0001;
      if (count == 16'hFFFF) begin
        ovfFlag <= 1'b1;
      end
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      convCount <= 8'h00;
    end else if (convStart) begin
      convCount <= convCount + 8'h01;
    end
  end
endmodule
